//--- hw/rsds_sequencer.v
// Reset merge, reset latch and start-up delay timing
`timescale 1ns/1ps
`default_nettype none
`include "rsds_regs.vh"
module rsds_sequencer #(
    // Long delays as parameters so a run can shorten them
    parameter POR_CYC = `RSDS_POR_US * `RSDS_CLK_MHZ,
    parameter WD_768_CYC = `RSDS_WD_768_US * `RSDS_CLK_MHZ,
    parameter WD_184_CYC = `RSDS_WD_184_US * `RSDS_CLK_MHZ,
    parameter WD_60MS_CYC = `RSDS_WD_60MS_US * `RSDS_CLK_MHZ,
    parameter WD_480_CYC = `RSDS_WD_480_US * `RSDS_CLK_MHZ,
    parameter WD_960_CYC = `RSDS_WD_960_US * `RSDS_CLK_MHZ,
    parameter WD_1920_CYC = `RSDS_WD_1920_US * `RSDS_CLK_MHZ
) (
    input wire clk,
    input wire rst,
    input wire ext_reset_pin_n,
    input wire brownout_det,
    input wire brownout_cfg_bit0,
    input wire brownout_cfg_bit1,
    input wire watchdog_reset_req,
    input wire wakeup_req,
    input wire powerdown_mode,
    input wire powerdown_clock_stop,
    input wire [2:0] wake_delay_select,
    input wire status_wr_en,
    input wire [7:0] status_wr_data,
    output wire internal_reset,
    output reg reset_done_q,
    output reg [2:0] reset_cause_q,
    output reg volatile_lost_q,
    output reg [11:0] pc_q,
    output reg [7:0] status_q,
    output reg [7:0] mode_q,
    output reg [7:0] option_q,
    output reg [7:0] port_dir_q,
    output reg [7:0] wake_edge_select_reg,
    output reg [7:0] wake_enable_reg,
    output reg [7:0] input_level_regs,
    output reg [7:0] schmitt_select_regs,
    output reg [7:0] pullup_select_regs,
    output reg [7:0] comparator_control_reg,
    output wire clock_run_in_powerdown
);

    // Cycles per ripple count, rounded up
    localparam TICK_CYC = (POR_CYC + 1023) / 1024;
    // Shortest wake delay fits below the parameter limit
    localparam WD_060_CYC = `RSDS_WD_060_US * `RSDS_CLK_MHZ;

    // Synchroniser stages for pin and brown-out
    reg pin_m_q;
    reg pin_s_q;
    reg bo_m_q;
    reg bo_s_q;
    // Reset latch and what set it
    reg latch_q;
    reg [2:0] src_q;
    // Power-down state seen when the reset began
    reg pd_at_q;
    // Prescaler and 10-bit ripple for power-up
    reg [31:0] tick_q;
    reg [9:0] drt_q;
    // Cycle counter for every other cause
    reg [31:0] cnt_q;
    // Combinational helpers
    reg [31:0] wake_cyc;
    reg [2:0] new_src;
    wire bo_en;
    wire ext_evt;
    wire bo_evt;
    wire any_evt;
    wire por_done;
    wire other_done;
    wire release_now;

    // Two flops each; only the second stage is read
    always @(posedge clk) begin
        if (rst) begin
            pin_m_q <= 1'b0;
            pin_s_q <= 1'b0;
            bo_m_q <= 1'b0;
            bo_s_q <= 1'b0;
        end else begin
            pin_m_q <= ext_reset_pin_n;
            pin_s_q <= pin_m_q;
            bo_m_q <= brownout_det;
            bo_s_q <= bo_m_q;
        end
    end

    // Fuse pair both set switches brown-out off
    assign bo_en = ({brownout_cfg_bit1, brownout_cfg_bit0} != `RSDS_BOR_OFF);
    // A low pin is a reset request for as long as it stays low
    assign ext_evt = ~pin_s_q;
    assign bo_evt = bo_s_q & bo_en;
    assign any_evt = ext_evt | bo_evt | watchdog_reset_req | wakeup_req;

    // Wake delay table in cycles
    always @* begin
        case (wake_delay_select)
            `RSDS_WSEL_NONE: wake_cyc = 32'h0;
            `RSDS_WSEL_060: wake_cyc = WD_060_CYC;
            `RSDS_WSEL_768: wake_cyc = WD_768_CYC;
            `RSDS_WSEL_184: wake_cyc = WD_184_CYC;
            `RSDS_WSEL_60MS: wake_cyc = WD_60MS_CYC;
            `RSDS_WSEL_480: wake_cyc = WD_480_CYC;
            `RSDS_WSEL_960: wake_cyc = WD_960_CYC;
            `RSDS_WSEL_1920: wake_cyc = WD_1920_CYC;
            default: wake_cyc = WD_184_CYC;
        endcase
    end

    // Cause priority: brown-out, watchdog, pin, wake
    always @* begin
        if (bo_evt) begin
            new_src = `RSDS_SRC_BOR;
        end else if (watchdog_reset_req) begin
            new_src = `RSDS_SRC_WDT;
        end else if (ext_evt) begin
            new_src = `RSDS_SRC_EXT;
        end else begin
            new_src = `RSDS_SRC_WAKE;
        end
    end

    // Power-up ends once all ten stages have rolled over
    assign por_done = (src_q == `RSDS_SRC_POR) && (drt_q == 10'h3ff) &&
                      (tick_q == TICK_CYC - 1);
    // Other causes end when the selected delay has run
    assign other_done = (src_q != `RSDS_SRC_POR) && (cnt_q >= wake_cyc);
    assign release_now = latch_q & ~any_evt & (por_done | other_done);

    // Reset latch and start-up delay timing
    always @(posedge clk) begin
        if (rst) begin
            // Power-up: latch set, cause recorded
            latch_q <= 1'b1;
            src_q <= `RSDS_SRC_POR;
            pd_at_q <= 1'b0;
            tick_q <= 32'h0;
            drt_q <= 10'h000;
            cnt_q <= 32'h0;
        end else if (any_evt) begin
            // Any request restarts the delay from zero
            latch_q <= 1'b1;
            tick_q <= 32'h0;
            drt_q <= 10'h000;
            cnt_q <= 32'h0;
            // A pending power-up keeps its full timing
            if (!(latch_q && src_q == `RSDS_SRC_POR)) begin
                src_q <= new_src;
            end
            // Mode captured only when the reset starts
            if (!latch_q) begin
                pd_at_q <= powerdown_mode;
            end
        end else if (release_now) begin
            latch_q <= 1'b0;
            tick_q <= 32'h0;
            drt_q <= 10'h000;
            cnt_q <= 32'h0;
        end else if (latch_q) begin
            // Ripple stages advance only for power-up
            if (src_q == `RSDS_SRC_POR) begin
                if (tick_q == TICK_CYC - 1) begin
                    tick_q <= 32'h0;
                    drt_q <= drt_q + 10'h001;
                end else begin
                    tick_q <= tick_q + 32'h1;
                end
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end

    assign internal_reset = latch_q;

    // Clock kept alive in power-down when stop bit clear
    assign clock_run_in_powerdown = ~powerdown_clock_stop;

    // Release pulse and the record of the last cause
    always @(posedge clk) begin
        if (rst) begin
            reset_done_q <= 1'b0;
            reset_cause_q <= `RSDS_SRC_POR;
            volatile_lost_q <= 1'b1;
        end else begin
            reset_done_q <= release_now;
            if (release_now) begin
                reset_cause_q <= src_q;
                // Power-up and brown-out lose volatile state
                volatile_lost_q <= (src_q == `RSDS_SRC_POR) ||
                                   (src_q == `RSDS_SRC_BOR);
            end
        end
    end

    // Fixed reset values, forced while the latch is set
    always @(posedge clk) begin
        if (rst || latch_q) begin
            pc_q <= `RSDS_PC_VEC;
            mode_q <= `RSDS_MODE_RST;
            option_q <= `RSDS_ONES_RST;
            port_dir_q <= `RSDS_ONES_RST;
            wake_edge_select_reg <= `RSDS_ONES_RST;
            wake_enable_reg <= `RSDS_ONES_RST;
            input_level_regs <= `RSDS_ONES_RST;
            schmitt_select_regs <= `RSDS_ONES_RST;
            pullup_select_regs <= `RSDS_ONES_RST;
            // Comparator held off and output disabled
            comparator_control_reg <= `RSDS_CMP_RST;
        end
    end

    // Status byte: software writes, reset edits its flags
    always @(posedge clk) begin
        if (rst) begin
            status_q <= `RSDS_STATUS_RST;
        end else if (release_now) begin
            // Top three bits cleared on every cause
            status_q[7:5] <= 3'h0;
            case (src_q)
                `RSDS_SRC_POR: begin
                    status_q[`RSDS_ST_TO] <= 1'b1;
                    status_q[`RSDS_ST_PD] <= 1'b1;
                end
                `RSDS_SRC_WDT: begin
                    // Flags tell sleeping from running timeout
                    status_q[`RSDS_ST_TO] <= 1'b0;
                    status_q[`RSDS_ST_PD] <= ~pd_at_q;
                end
                `RSDS_SRC_EXT: begin
                    // Running pin reset leaves both flags alone
                    if (pd_at_q) begin
                        status_q[`RSDS_ST_TO] <= 1'b1;
                        status_q[`RSDS_ST_PD] <= 1'b0;
                    end
                end
                default: begin
                    // Wake and brown-out keep the flags as found
                    status_q[`RSDS_ST_TO] <= status_q[`RSDS_ST_TO];
                end
            endcase
        end else if (status_wr_en && !latch_q) begin
            // Writes ignored while reset is held
            status_q <= status_wr_data;
        end
    end

endmodule // rsds_sequencer
`default_nettype wire

//--- common/rsds_regs.vh
// Constants for the reset and start-up delay sequencer
`ifndef RSDS_REGS_VH
`define RSDS_REGS_VH
// System clock rate in MHz
`define RSDS_CLK_MHZ 50
// Power-up start-up delay in microseconds
`define RSDS_POR_US 72000
// Stages of the power-up ripple counter
`define RSDS_DRT_BITS 10
// Wake delay figures in microseconds
`define RSDS_WD_060_US 60
`define RSDS_WD_768_US 7680
`define RSDS_WD_184_US 18400
`define RSDS_WD_60MS_US 60000
`define RSDS_WD_480_US 480000
`define RSDS_WD_960_US 960000
`define RSDS_WD_1920_US 1920000
// Wake delay select codes
`define RSDS_WSEL_NONE 3'h4
`define RSDS_WSEL_060 3'h5
`define RSDS_WSEL_768 3'h6
`define RSDS_WSEL_184 3'h7
`define RSDS_WSEL_60MS 3'h0
`define RSDS_WSEL_480 3'h1
`define RSDS_WSEL_960 3'h2
`define RSDS_WSEL_1920 3'h3
// Reset cause codes
`define RSDS_SRC_POR 3'h0
`define RSDS_SRC_BOR 3'h1
`define RSDS_SRC_WDT 3'h2
`define RSDS_SRC_EXT 3'h3
`define RSDS_SRC_WAKE 3'h4
// Fuse pair value that switches brown-out off
`define RSDS_BOR_OFF 2'h3
// Reset values
`define RSDS_PC_VEC 12'hfff
`define RSDS_MODE_RST 8'h1f
`define RSDS_ONES_RST 8'hff
`define RSDS_CMP_RST 8'hc1
`define RSDS_STATUS_RST 8'h00
// Status field positions
`define RSDS_ST_PD 3
`define RSDS_ST_TO 4
`endif

//--- tb/rsds_chk.sv
// Assertion checker for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rsds_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_reset_pin_n,
    input wire logic brownout_det,
    input wire logic brownout_cfg_bit0,
    input wire logic brownout_cfg_bit1,
    input wire logic watchdog_reset_req,
    input wire logic internal_reset,
    input wire logic reset_done_q,
    input wire logic [2:0] reset_cause_q,
    input wire logic [11:0] pc_q,
    input wire logic [7:0] status_q,
    input wire logic [7:0] mode_q,
    input wire logic [7:0] comparator_control_reg
);
    // Brown-out request with the fuse pair not both set
    wire bor_on = brownout_det && !(brownout_cfg_bit0 && brownout_cfg_bit1);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Reset images load while the latch holds
    pc_vec_a: assert property (internal_reset |=> pc_q == 12'hfff)
        else $error("pc off vector");
    mode_img_a: assert property (internal_reset |=> mode_q == 8'h1f)
        else $error("mode image");
    cmp_img_a: assert property (internal_reset |=> (comparator_control_reg & 8'hc1) == 8'hc1)
        else $error("comparator image");
    // Pin and brown-out requests reach the latch after their sync stages, watchdog on the next cycle
    wdt_take_a: assert property (watchdog_reset_req |=> internal_reset)
        else $error("watchdog missed");
    bor_hold_a: assert property (bor_on [*3] |=> internal_reset)
        else $error("brown-out missed");
    pin_hold_a: assert property (!ext_reset_pin_n [*3] |=> internal_reset)
        else $error("pin missed");
    // Release brings one done pulse and the power-up flags
    done_pulse_a: assert property ($fell(internal_reset) |-> ##[0:1] reset_done_q)
        else $error("no done pulse");
    por_flags_a: assert property (reset_done_q && reset_cause_q == 3'h0 |-> status_q[7:3] == 5'h03)
        else $error("power-up flags");
    cover property (reset_done_q && reset_cause_q == 3'h1);
    cover property (reset_done_q && reset_cause_q == 3'h2);
    cover property (reset_done_q && reset_cause_q == 3'h3);
endmodule // rsds_chk
bind rsds_sequencer rsds_chk i_rsds_chk (.clk(clk), .rst(rst), .ext_reset_pin_n(ext_reset_pin_n),
    .brownout_det(brownout_det), .brownout_cfg_bit0(brownout_cfg_bit0), .brownout_cfg_bit1(brownout_cfg_bit1),
    .watchdog_reset_req(watchdog_reset_req), .internal_reset(internal_reset), .reset_done_q(reset_done_q),
    .reset_cause_q(reset_cause_q), .pc_q(pc_q), .status_q(status_q), .mode_q(mode_q),
    .comparator_control_reg(comparator_control_reg));
`default_nettype wire

//--- tb/rsds_board.sv
// Board model: reset button and RC tail on the pin
`timescale 1ns/1ps
`default_nettype none
module rsds_board (
    input wire logic clk,
    input wire logic press,
    input wire logic slow,
    output wire logic ext_reset_pin_n
);
    // Cycles left before the RC tail lets the pin rise
    logic [3:0] rc_q = 4'h0;
    // A slow board holds the pin low eight cycles past release
    always @(posedge clk) begin
        rc_q <= press ? (slow ? 4'h8 : 4'h0) : rc_q - 4'(rc_q != 4'h0);
    end
    // Pull-up wins once button and tail are gone
    assign ext_reset_pin_n = !press && rc_q == 4'h0;
endmodule // rsds_board
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, press = 1'b1, slow = 1'b1, bor = 1'b0;
    logic wdt = 1'b0, wake = 1'b0, pdm = 1'b0, stop = 1'b0, swe = 1'b0;
    logic [1:0] fuse = 2'h0;
    logic [2:0] wsel = 3'h7;
    logic [7:0] swd = 8'h00;
    wire pin_n, irst, done, vlost, runpd;
    wire [2:0] cause;
    wire [11:0] pc;
    wire [7:0] st, mode, opt, cmp, pdir, wedge, wen, lvl, smt, pup;
    int fail_count = 0;
    int comparisons = 0;
    // Release delay per wake code at the shortened lengths
    int dly [8] = '{300, 400, 500, 600, 0, 3000, 100, 200};
    always #10 clk = ~clk;
    rsds_board i_rsds_board (.clk(clk), .press(press), .slow(slow), .ext_reset_pin_n(pin_n));
    rsds_sequencer #(.POR_CYC(2048), .WD_768_CYC(100), .WD_184_CYC(200), .WD_60MS_CYC(300),
        .WD_480_CYC(400), .WD_960_CYC(500), .WD_1920_CYC(600)) i_rsds_sequencer (.clk(clk), .rst(rst),
        .ext_reset_pin_n(pin_n), .brownout_det(bor), .brownout_cfg_bit0(fuse[0]), .brownout_cfg_bit1(fuse[1]),
        .watchdog_reset_req(wdt), .wakeup_req(wake), .powerdown_mode(pdm), .powerdown_clock_stop(stop),
        .wake_delay_select(wsel), .status_wr_en(swe), .status_wr_data(swd), .internal_reset(irst),
        .reset_done_q(done), .reset_cause_q(cause), .volatile_lost_q(vlost), .pc_q(pc), .status_q(st),
        .mode_q(mode), .option_q(opt), .port_dir_q(pdir), .wake_edge_select_reg(wedge), .wake_enable_reg(wen),
        .input_level_regs(lvl), .schmitt_select_regs(smt), .pullup_select_regs(pup), .comparator_control_reg(cmp),
        .clock_run_in_powerdown(runpd));
    // Count one comparison, report a mismatch
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Wait for done; release must come d to d+8 cycles on
    task automatic settle(input int d);
        int n;
        n = 0;
        while (done !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > d + 8) begin
                fail_count++;
                $display("unexpected at %0t: no release", $time);
                print_verdict();
            end
        end
        chk(12'(n >= d), 12'h1);
    endtask
    // One-cycle request: 0 watchdog, 1 wake, 2 pin
    task automatic pulse(input int k, input logic [7:0] s);
        @(posedge clk);
        swe <= 1'b1;
        swd <= s;
        @(posedge clk);
        swe <= 1'b0;
        wdt <= k == 0;
        wake <= k == 1;
        press <= k == 2;
        @(posedge clk);
        wdt <= 1'b0;
        wake <= 1'b0;
        press <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Pin held low: no count may start
        repeat (3000) @(posedge clk);
        chk(12'(irst), 12'h1);
        press <= 1'b0;
        settle(2056);
        chk(pc, 12'hfff);
        chk(12'(mode), 12'h1f);
        chk(12'(opt), 12'hff);
        // The other all-ones images must read back as ones together
        chk(12'(pdir & wedge & wen), 12'hff);
        chk(12'(lvl & smt & pup), 12'hff);
        chk(12'(cause), 12'h0);
        chk(12'(cmp & 8'hc1), 12'hc1);
        chk(12'(st[7:3]), 12'h3);
        chk(12'(vlost), 12'h1);
        chk(12'(runpd), 12'h1);
        $display("test power-up done");
        slow <= 1'b0;
        wsel <= 3'h6;
        pulse(2, 8'hff);
        settle(100);
        chk(12'(st), 12'h1f);
        chk(12'(vlost), 12'h0);
        chk(12'(cause), 12'h3);
        // Every wake code, watchdog while running
        for (int c = 0; c < 8; c++) begin
            wsel <= c[2:0];
            pulse(0, 8'h00);
            settle(dly[c]);
            chk(12'(st[4:3]), 12'h1);
            chk(12'(cause), 12'h2);
        end
        $display("test wake codes done");
        // Asleep: watchdog clears both flags, pin sets timeout
        pdm <= 1'b1;
        wsel <= 3'h4;
        pulse(0, 8'h00);
        settle(0);
        chk(12'(st[4:3]), 12'h0);
        pulse(2, 8'h00);
        settle(0);
        chk(12'(st[4:3]), 12'h2);
        pdm <= 1'b0;
        pulse(1, 8'hea);
        settle(0);
        chk(12'({cause, st}), 12'h40a);
        $display("test sleep and wake done");
        bor <= 1'b1;
        repeat (40) @(posedge clk);
        chk(12'(irst), 12'h1);
        bor <= 1'b0;
        settle(0);
        chk(12'({cause, vlost}), 12'h3);
        // Both fuse bits set: brown-out ignored
        fuse <= 2'h3;
        bor <= 1'b1;
        stop <= 1'b1;
        repeat (40) @(posedge clk);
        chk(12'(irst), 12'h0);
        chk(12'(runpd), 12'h0);
        $display("test brown-out done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
